/* File: hdl/compare_skip_branch_exec.sv */
// Execution unit for compare, bit-test skip and conditional branch operations.
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/100ps
module compare_skip_branch_exec (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    cse_pkg::state_t state_r;
    cse_pkg::state_t state_nxt;
    cse_pkg::cmd_t cmd_r;
    cse_pkg::kind_t kind;
    cse_pkg::cmp_flags_t cmp_flags;
    logic [7:0] opa_r;
    logic [7:0] opb_r;
    logic [6:0] offs_r;
    logic [15:0] pc_r;
    logic [15:0] pc_nxt;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic two_word_r;
    logic taken_r;
    logic err_r;
    logic [1:0] last_cyc_r;
    logic [1:0] cyc_nxt;
    logic [1:0] hold_cnt_r;
    logic cond;
    logic taken_nxt;
    logic err_nxt;
    logic wait_r;
    logic [31:0] rdata_r;
    logic busy;
    logic wr_commit;
    logic [15:0] offs_ext;
    logic cmp_borrow;
    logic signed_less;

    assign busy = (state_r != cse_pkg::ST_IDLE);
    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;
    assign wr_commit = avs_write & ~wait_r;
    assign offs_ext = {{9{offs_r[6]}}, offs_r};

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // Writes are held off while an operation runs so that operands, the
    // counter and the flags cannot change under it; reads always pass.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_r <= 1'b1;
        end else if (ce) begin
            if (wait_r && (avs_read || (avs_write && !busy))) begin
                wait_r <= 1'b0;
            end else begin
                wait_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (ce && wait_r && avs_read) begin
            if (avs_address == cse_pkg::ADDR_CMD) begin
                rdata_r <= {24'h00_0000, cmd_r};
            end else if (avs_address == cse_pkg::ADDR_OPA) begin
                rdata_r <= {24'h00_0000, opa_r};
            end else if (avs_address == cse_pkg::ADDR_OPB) begin
                rdata_r <= {24'h00_0000, opb_r};
            end else if (avs_address == cse_pkg::ADDR_OFFS) begin
                rdata_r <= {25'h000_0000, offs_r};
            end else if (avs_address == cse_pkg::ADDR_PC) begin
                rdata_r <= {16'h0000, pc_r};
            end else if (avs_address == cse_pkg::ADDR_FLAGS) begin
                rdata_r <= {24'h00_0000, flags_r};
            end else if (avs_address == cse_pkg::ADDR_NEXTLEN) begin
                rdata_r <= {31'h0000_0000, two_word_r};
            end else if (avs_address == cse_pkg::ADDR_STATUS) begin
                rdata_r <= {27'h000_0000, err_r, last_cyc_r, taken_r, busy};
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------------------------------
    // Operand registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            opa_r <= cse_pkg::OPER_RST;
            opb_r <= cse_pkg::OPER_RST;
            offs_r <= cse_pkg::OFFS_RST;
            two_word_r <= 1'b0;
        end else if (ce && wr_commit && avs_byteenable[0]) begin
            if (avs_address == cse_pkg::ADDR_OPA) begin
                opa_r <= avs_writedata[7:0];
            end else if (avs_address == cse_pkg::ADDR_OPB) begin
                opb_r <= avs_writedata[7:0];
            end else if (avs_address == cse_pkg::ADDR_OFFS) begin
                offs_r <= avs_writedata[6:0];
            end else if (avs_address == cse_pkg::ADDR_NEXTLEN) begin
                two_word_r <= avs_writedata[cse_pkg::NEXTLEN_TWO_POS];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_r <= '0;
        end else if (ce && wr_commit && avs_byteenable[0]
                && avs_address == cse_pkg::ADDR_CMD) begin
            cmd_r <= avs_writedata[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Compare datapath
    // ----------------------------------------------------------------
    // Carry feeds borrow for OP_CMP_CARRY only; OP_CMP_IMM subtracts with no borrow.
    assign cmp_borrow = (cmd_r.op == cse_pkg::OP_CMP_CARRY) ? flags_r[cse_pkg::FLAG_C] : 1'b0;

    cmp_flags_unit u_cmp (
        .minuend(opa_r),
        .subtrahend(opb_r),
        .borrow_in(cmp_borrow),
        .flags(cmp_flags)
    );

    assign signed_less = flags_r[cse_pkg::FLAG_N] ^ flags_r[cse_pkg::FLAG_V];

    // ----------------------------------------------------------------
    // Condition decode
    // ----------------------------------------------------------------
    always_comb begin
        cond = 1'b0;
        kind = cse_pkg::KIND_BRANCH;
        case (cmd_r.op)
            cse_pkg::OP_CMP_CARRY,
            cse_pkg::OP_CMP_IMM: begin
                kind = cse_pkg::KIND_CMP;
            end
            cse_pkg::OP_SKIP_REG_BIT_CLEAR: begin
                kind = cse_pkg::KIND_SKIP;
                cond = ~opa_r[cmd_r.sel];
            end
            cse_pkg::OP_SKIP_REG_BIT_SET: begin
                kind = cse_pkg::KIND_SKIP;
                cond = opa_r[cmd_r.sel];
            end
            cse_pkg::OP_SKIP_IO_BIT_CLEAR: begin
                kind = cse_pkg::KIND_SKIP;
                cond = ~opb_r[cmd_r.sel];
            end
            cse_pkg::OP_SKIP_IO_BIT_SET: begin
                kind = cse_pkg::KIND_SKIP;
                cond = opb_r[cmd_r.sel];
            end
            cse_pkg::OP_BRANCH_FLAG_SET: begin
                cond = flags_r[cmd_r.sel];
            end
            cse_pkg::OP_BRANCH_FLAG_CLEAR: begin
                cond = ~flags_r[cmd_r.sel];
            end
            cse_pkg::OP_BRANCH_EQUAL: begin
                cond = flags_r[cse_pkg::FLAG_Z];
            end
            cse_pkg::OP_BRANCH_NOT_EQUAL: begin
                cond = ~flags_r[cse_pkg::FLAG_Z];
            end
            cse_pkg::OP_BRANCH_CARRY_SET: begin
                cond = flags_r[cse_pkg::FLAG_C];
            end
            cse_pkg::OP_BRANCH_CARRY_CLEAR: begin
                cond = ~flags_r[cse_pkg::FLAG_C];
            end
            cse_pkg::OP_BRANCH_SAME_OR_HIGHER: begin
                cond = ~flags_r[cse_pkg::FLAG_C];
            end
            cse_pkg::OP_BRANCH_LOWER: begin
                cond = flags_r[cse_pkg::FLAG_C];
            end
            cse_pkg::OP_BRANCH_NEGATIVE: begin
                cond = flags_r[cse_pkg::FLAG_N];
            end
            cse_pkg::OP_BRANCH_POSITIVE: begin
                cond = ~flags_r[cse_pkg::FLAG_N];
            end
            cse_pkg::OP_BRANCH_SIGNED_GE: begin
                cond = ~signed_less;
            end
            cse_pkg::OP_BRANCH_SIGNED_LT: begin
                cond = signed_less;
            end
            cse_pkg::OP_BRANCH_HALF_CARRY_SET: begin
                cond = flags_r[cse_pkg::FLAG_H];
            end
            cse_pkg::OP_BRANCH_HALF_CARRY_CLEAR: begin
                cond = ~flags_r[cse_pkg::FLAG_H];
            end
            cse_pkg::OP_BRANCH_TRANSFER_SET: begin
                cond = flags_r[cse_pkg::FLAG_T];
            end
            default: begin
                kind = cse_pkg::KIND_NONE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Outcome: next counter, flags and cycle count
    // ----------------------------------------------------------------
    always_comb begin
        pc_nxt = pc_r + cse_pkg::PC_STEP;
        flags_nxt = flags_r;
        cyc_nxt = cse_pkg::CYC_ONE;
        taken_nxt = 1'b0;
        err_nxt = 1'b0;
        case (kind)
            cse_pkg::KIND_CMP: begin
                flags_nxt[cse_pkg::FLAG_Z] = cmp_flags.z;
                flags_nxt[cse_pkg::FLAG_N] = cmp_flags.n;
                flags_nxt[cse_pkg::FLAG_V] = cmp_flags.v;
                flags_nxt[cse_pkg::FLAG_C] = cmp_flags.c;
                flags_nxt[cse_pkg::FLAG_H] = cmp_flags.h;
            end
            cse_pkg::KIND_SKIP: begin
                taken_nxt = cond;
                if (cond && two_word_r) begin
                    pc_nxt = pc_r + cse_pkg::PC_SKIP_TWO;
                    cyc_nxt = cse_pkg::CYC_THREE;
                end else if (cond) begin
                    pc_nxt = pc_r + cse_pkg::PC_SKIP_ONE;
                    cyc_nxt = cse_pkg::CYC_TWO;
                end
            end
            cse_pkg::KIND_BRANCH: begin
                taken_nxt = cond;
                if (cond) begin
                    pc_nxt = pc_r + offs_ext + cse_pkg::PC_STEP;
                    cyc_nxt = cse_pkg::CYC_TWO;
                end
            end
            default: begin
                // Unknown codes retire as a one-cycle step and raise the error bit.
                err_nxt = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            cse_pkg::ST_IDLE: begin
                if (wr_commit && avs_byteenable[0] && avs_address == cse_pkg::ADDR_CMD) begin
                    state_nxt = cse_pkg::ST_EXEC;
                end
            end
            cse_pkg::ST_EXEC: begin
                if (cyc_nxt == cse_pkg::CYC_ONE) begin
                    state_nxt = cse_pkg::ST_IDLE;
                end else begin
                    state_nxt = cse_pkg::ST_HOLD;
                end
            end
            cse_pkg::ST_HOLD: begin
                if (hold_cnt_r == cse_pkg::CYC_ONE) begin
                    state_nxt = cse_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = cse_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= cse_pkg::ST_IDLE;
        end else if (ce) begin
            state_r <= state_nxt;
        end
    end

    // Counts the extra busy cycles of a taken skip or a taken branch.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold_cnt_r <= 2'h0;
        end else if (ce) begin
            if (state_r == cse_pkg::ST_EXEC) begin
                hold_cnt_r <= cyc_nxt - cse_pkg::CYC_ONE;
            end else if (state_r == cse_pkg::ST_HOLD) begin
                hold_cnt_r <= hold_cnt_r - cse_pkg::CYC_ONE;
            end
        end
    end

    // ----------------------------------------------------------------
    // Program counter and flags
    // ----------------------------------------------------------------
    // Both are written by software only while idle, so the execute step
    // never races a bus write.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_r <= cse_pkg::PC_RST;
        end else if (ce) begin
            if (state_r == cse_pkg::ST_EXEC) begin
                pc_r <= pc_nxt;
            end else if (wr_commit && avs_address == cse_pkg::ADDR_PC) begin
                if (avs_byteenable[0]) begin
                    pc_r[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    pc_r[15:8] <= avs_writedata[15:8];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_r <= cse_pkg::FLAGS_RST;
        end else if (ce) begin
            if (state_r == cse_pkg::ST_EXEC) begin
                flags_r <= flags_nxt;
            end else if (wr_commit && avs_byteenable[0]
                    && avs_address == cse_pkg::ADDR_FLAGS) begin
                flags_r <= avs_writedata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Outcome status
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            taken_r <= 1'b0;
            err_r <= 1'b0;
            last_cyc_r <= 2'h0;
        end else if (ce && state_r == cse_pkg::ST_EXEC) begin
            taken_r <= taken_nxt;
            err_r <= err_nxt;
            last_cyc_r <= cyc_nxt;
        end
    end

endmodule // compare_skip_branch_exec

/* File: hdl/cse_pkg.sv */
// Constants, types and register map of the compare, skip and branch execution block.
package cse_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_CMD = 5'h00;
    localparam logic [4:0] ADDR_OPA = 5'h04;
    localparam logic [4:0] ADDR_OPB = 5'h08;
    localparam logic [4:0] ADDR_OFFS = 5'h0C;
    localparam logic [4:0] ADDR_PC = 5'h10;
    localparam logic [4:0] ADDR_FLAGS = 5'h14;
    localparam logic [4:0] ADDR_NEXTLEN = 5'h18;
    localparam logic [4:0] ADDR_STATUS = 5'h1C;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SEL_LSB = 5;
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_TAKEN_POS = 1;
    localparam int STAT_CYC_LSB = 2;
    localparam int STAT_ERR_POS = 4;
    localparam int NEXTLEN_TWO_POS = 0;

    // Bit positions inside the status flags register.
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] OPER_RST = 8'h00;
    localparam logic [6:0] OFFS_RST = 7'h00;

    // ----------------------------------------------------------------
    // Cycle counts and program counter steps
    // ----------------------------------------------------------------
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam logic [15:0] PC_STEP = 16'h0001;
    localparam logic [15:0] PC_SKIP_ONE = 16'h0002;
    localparam logic [15:0] PC_SKIP_TWO = 16'h0003;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_CMP_CARRY = 5'h00,
        OP_CMP_IMM = 5'h01,
        OP_SKIP_REG_BIT_CLEAR = 5'h02,
        OP_SKIP_REG_BIT_SET = 5'h03,
        OP_SKIP_IO_BIT_CLEAR = 5'h04,
        OP_SKIP_IO_BIT_SET = 5'h05,
        OP_BRANCH_FLAG_SET = 5'h06,
        OP_BRANCH_FLAG_CLEAR = 5'h07,
        OP_BRANCH_EQUAL = 5'h08,
        OP_BRANCH_NOT_EQUAL = 5'h09,
        OP_BRANCH_CARRY_SET = 5'h0A,
        OP_BRANCH_CARRY_CLEAR = 5'h0B,
        OP_BRANCH_SAME_OR_HIGHER = 5'h0C,
        OP_BRANCH_LOWER = 5'h0D,
        OP_BRANCH_NEGATIVE = 5'h0E,
        OP_BRANCH_POSITIVE = 5'h0F,
        OP_BRANCH_SIGNED_GE = 5'h10,
        OP_BRANCH_SIGNED_LT = 5'h11,
        OP_BRANCH_HALF_CARRY_SET = 5'h12,
        OP_BRANCH_HALF_CARRY_CLEAR = 5'h13,
        OP_BRANCH_TRANSFER_SET = 5'h14
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_HOLD = 3'b100
    } state_t;

    typedef enum logic [1:0] {
        KIND_NONE = 2'h0,
        KIND_CMP = 2'h1,
        KIND_SKIP = 2'h2,
        KIND_BRANCH = 2'h3
    } kind_t;

    typedef struct packed {
        logic [2:0] sel;
        logic [4:0] op;
    } cmd_t;

    typedef struct packed {
        logic h;
        logic v;
        logic n;
        logic z;
        logic c;
    } cmp_flags_t;

endpackage

/* File: hdl/cmp_flags_unit.sv */
// Subtract-and-discard unit that produces compare flags.
`timescale 1ns/100ps
module cmp_flags_unit (
    // Operands
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    input wire logic borrow_in,
    // Result flags
    output cse_pkg::cmp_flags_t flags
);

    logic [8:0] diff;
    logic [7:0] res;

    // ----------------------------------------------------------------
    // Difference
    // ----------------------------------------------------------------
    // The result is never stored; only the flags leave this unit.
    assign diff = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
    assign res = diff[7:0];

    // ----------------------------------------------------------------
    // Flags
    // ----------------------------------------------------------------
    assign flags.c = diff[8];
    assign flags.z = (res == 8'h00);
    assign flags.n = res[7];
    assign flags.v = (minuend[7] & ~subtrahend[7] & ~res[7])
        | (~minuend[7] & subtrahend[7] & res[7]);
    assign flags.h = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & res[3])
        | (res[3] & ~minuend[3]);

endmodule // cmp_flags_unit

/* File: verification/cse_monitor.sv */
// Bus timing checker for the compare, skip and branch execution block.
`timescale 1ns/100ps
module cse_monitor (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_rd_ans; avs_read && avs_waitrequest && ce |=> !avs_waitrequest; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered next cycle");
    property p_one_low; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_one_low: assert property (p_one_low) else $error("waitrequest low too long");
    property p_low_cause; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
    a_low_cause: assert property (p_low_cause) else $error("answer without request");
    // Busy lasts three cycles at most, so a held write lands soon.
    property p_wr_ans; avs_write && avs_waitrequest |-> ##[1:5] !avs_waitrequest; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write held too long");
    property p_unmap;
        avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_pc_w; avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0; endproperty
    a_pc_w: assert property (p_pc_w) else $error("upper read bits set");
    property p_byte_w;
        avs_read && !avs_waitrequest && avs_address != cse_pkg::ADDR_PC
            |-> avs_readdata[31:8] == 24'h0;
    endproperty
    a_byte_w: assert property (p_byte_w) else $error("byte register too wide");
    property p_hold; !(avs_read && avs_waitrequest && ce) |=> $stable(avs_readdata); endproperty
    a_hold: assert property (p_hold) else $error("read data changed unasked");
endmodule // cse_monitor

bind compare_skip_branch_exec cse_monitor u_mon (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
);

/* File: verification/cse_host_model.sv */
// Avalon-MM master model that feeds operand and command words to the block.
`timescale 1ns/100ps
module cse_host_model (
    // Clock
    input wire logic clk,
    // Avalon-MM master
    output logic [4:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    initial begin
        avs_address = 5'h1F;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'hFFFFFFFF;
        avs_byteenable = 4'h0;
    end
    // An idle edge first keeps a strobe from being set twice in one step.
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                        input logic [3:0] be, output logic [31:0] rd);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // Released address and data lines show the inverse, never the last value; byteenable keeps it.
        avs_address <= ~a;
        avs_writedata <= ~wd;
    endtask
endmodule // cse_host_model

/* File: verification/compare_skip_branch_exec_test.sv */
// Self-checking bench for the compare, skip and branch execution block.
`timescale 1ns/100ps
module compare_skip_branch_exec_test;
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] a;
        logic [7:0] b;
        logic [6:0] k;
        logic [7:0] f;
        logic nl;
        logic [15:0] pc;
        logic [7:0] ef;
        logic [4:0] st;
    } row_t;
    logic clk;
    logic sys_rst;
    logic ce;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [31:0] rv;
    int err_total = 0, checks_done = 0, cyc = 0;
    row_t rows [23];

    compare_skip_branch_exec u_dut (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );
    cse_host_model u_host (
        .clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
    );

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        u_host.xfer(1'b1, a, d, be, rv);
    endtask
    task automatic rd(input logic [4:0] a);
        u_host.xfer(1'b0, a, 32'h0, 4'hF, rv);
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // A run needs under eight hundred cycles; a hang is cut well after.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        rows[0] = '{8'h00, 8'h10, 8'h01, 7'h00, 8'h01, 1'h0, 16'h0101, 8'h20, 5'h04};
        rows[1] = '{8'h00, 8'h80, 8'h7F, 7'h00, 8'h41, 1'h0, 16'h0101, 8'h6A, 5'h04};
        rows[2] = '{8'h01, 8'h07, 8'h07, 7'h00, 8'h11, 1'h0, 16'h0101, 8'h12, 5'h04};
        rows[3] = '{8'h62, 8'hF7, 8'h00, 7'h00, 8'h00, 1'h0, 16'h0102, 8'h00, 5'h0A};
        rows[4] = '{8'hE3, 8'h80, 8'h00, 7'h00, 8'h00, 1'h1, 16'h0103, 8'h00, 5'h0E};
        rows[5] = '{8'h04, 8'h00, 8'h01, 7'h00, 8'h00, 1'h0, 16'h0101, 8'h00, 5'h04};
        rows[6] = '{8'h05, 8'h00, 8'h01, 7'h00, 8'h00, 1'h1, 16'h0103, 8'h00, 5'h0E};
        rows[7] = '{8'hC6, 8'h00, 8'h00, 7'h05, 8'h40, 1'h0, 16'h0106, 8'h40, 5'h0A};
        rows[8] = '{8'h47, 8'h00, 8'h00, 7'h05, 8'h04, 1'h0, 16'h0101, 8'h04, 5'h04};
        rows[9] = '{8'h08, 8'h00, 8'h00, 7'h7E, 8'h02, 1'h0, 16'h00FF, 8'h02, 5'h0A};
        rows[10] = '{8'h09, 8'h00, 8'h00, 7'h05, 8'h02, 1'h0, 16'h0101, 8'h02, 5'h04};
        rows[11] = '{8'h0A, 8'h00, 8'h00, 7'h05, 8'h01, 1'h0, 16'h0106, 8'h01, 5'h0A};
        rows[12] = '{8'h0B, 8'h00, 8'h00, 7'h05, 8'h01, 1'h0, 16'h0101, 8'h01, 5'h04};
        rows[13] = '{8'h0C, 8'h00, 8'h00, 7'h40, 8'h00, 1'h0, 16'h00C1, 8'h00, 5'h0A};
        rows[14] = '{8'h0D, 8'h00, 8'h00, 7'h05, 8'h00, 1'h0, 16'h0101, 8'h00, 5'h04};
        rows[15] = '{8'h0E, 8'h00, 8'h00, 7'h3F, 8'h04, 1'h0, 16'h0140, 8'h04, 5'h0A};
        rows[16] = '{8'h0F, 8'h00, 8'h00, 7'h05, 8'h04, 1'h0, 16'h0101, 8'h04, 5'h04};
        rows[17] = '{8'h10, 8'h00, 8'h00, 7'h05, 8'h0C, 1'h0, 16'h0106, 8'h0C, 5'h0A};
        rows[18] = '{8'h11, 8'h00, 8'h00, 7'h05, 8'h04, 1'h0, 16'h0106, 8'h04, 5'h0A};
        rows[19] = '{8'h12, 8'h00, 8'h00, 7'h05, 8'h20, 1'h0, 16'h0106, 8'h20, 5'h0A};
        rows[20] = '{8'h13, 8'h00, 8'h00, 7'h05, 8'h20, 1'h0, 16'h0101, 8'h20, 5'h04};
        rows[21] = '{8'h14, 8'h00, 8'h00, 7'h05, 8'h40, 1'h0, 16'h0106, 8'h40, 5'h0A};
        rows[22] = '{8'h15, 8'h00, 8'h00, 7'h05, 8'h00, 1'h0, 16'h0101, 8'h00, 5'h14};
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(5'(i * 4));
            check("reset word", rv, 32'h0);
        end
        foreach (rows[i]) begin
            wr(cse_pkg::ADDR_OPA, {24'h0, rows[i].a}, 4'hF);
            wr(cse_pkg::ADDR_OPB, {24'h0, rows[i].b}, 4'hF);
            wr(cse_pkg::ADDR_OFFS, {25'h0, rows[i].k}, 4'hF);
            wr(cse_pkg::ADDR_PC, 32'h00000100, 4'hF);
            wr(cse_pkg::ADDR_FLAGS, {24'h0, rows[i].f}, 4'hF);
            wr(cse_pkg::ADDR_NEXTLEN, {31'h0, rows[i].nl}, 4'hF);
            wr(cse_pkg::ADDR_CMD, {24'h0, rows[i].cmd}, 4'hF);
            rd(cse_pkg::ADDR_PC);
            check("pc", rv, {16'h0, rows[i].pc});
            rd(cse_pkg::ADDR_FLAGS);
            check("flags", rv, {24'h0, rows[i].ef});
            rd(cse_pkg::ADDR_STATUS);
            check("status", rv, {27'h0, rows[i].st});
        end
        rd(5'h02);
        check("unmapped", rv, 32'h0);
        // Lane 0 off leaves the flags alone; the program counter takes lane 1 only.
        wr(cse_pkg::ADDR_FLAGS, 32'h000000FF, 4'hE);
        wr(cse_pkg::ADDR_PC, 32'h00001234, 4'h2);
        rd(cse_pkg::ADDR_FLAGS);
        check("flags lanes", rv, 32'h0);
        rd(cse_pkg::ADDR_PC);
        check("pc lanes", rv, 32'h00001201);
        // A low clock enable freezes a three-cycle skip, so it is still busy after.
        wr(cse_pkg::ADDR_NEXTLEN, 32'h00000001, 4'hF);
        wr(cse_pkg::ADDR_OPA, 32'h00000080, 4'hF);
        wr(cse_pkg::ADDR_CMD, 32'h000000E3, 4'hF);
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        rd(cse_pkg::ADDR_STATUS);
        check("busy", {31'h0, rv[0]}, 32'h00000001);
        rd(cse_pkg::ADDR_PC);
        check("pc skip", rv, 32'h00001204);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(cse_pkg::ADDR_PC);
        check("pc reset", rv, 32'h0);
        tally_and_finish();
    end
endmodule // compare_skip_branch_exec_test
